// *** rtl/ptce_event_irq.v ***
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ptce_consts.vh"

// How it works
// - Compare event drives each pin: pulse, toggle or timer status copy.
// - Pin is driven only while its output enable bit is set.
// - Pin level polarity comes from its event polarity bit.
// - Pin buffer type comes from its ordinary buffer type bit.
// - Pin 8 mode is config bits 2:1, read/write, reset 00.
// - Reload/add bit 0: zero reloads target, one adds to target.
// - Add mode increases 64-bit target by low reload/add value.
// - Writing one clears a status bit; zero leaves it.
// - Enabled status bits OR into system status bit 29.
// - Enable bits 24:16 read/write, reset zero, gate status 8:0.
// - Status bits set on events regardless of enables.
// - System interrupt needs local enable and system enable bit 29.
// - Bits 8 and 7 set on port 2 receive and transmit captures.
// - Bits 6 and 5 set on port 1 receive and transmit captures.
// - Bit 4 sets on capture of packet leaving fabric to external port.
// - Timer bit 0 sets when clock equals or passes target.
// - Pin 9 mode is config bits 4:3, same coding, reset 00.
module ptce_event_irq #(
  parameter PULSE_NS = `PTCE_PULSE_NS,
  parameter CLK_NS = `PTCE_CLK_NS
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [63:0] ptp_clock,
  input wire [8:1] capture_event,
  output wire [1:0] event_pin_out,
  output wire [1:0] event_pin_oe,
  output wire [1:0] event_pin_buf_type,
  output wire irq
);
  localparam PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam [7:0] PULSE_LEN = PULSE_CYC[7:0];
  localparam SW = `PTCE_STS_W;

  reg [63:0] target_reg;
  reg [63:0] reload_reg;
  reg [4:0] cfg_reg;
  reg [5:0] pincfg_reg;
  reg [SW-1:0] sts_reg;
  reg [SW-1:0] en_reg;
  reg sys_flag_reg;
  reg sys_en_reg;
  reg armed_reg;
  reg armed_next;
  reg [SW-1:0] sts_next;
  reg [31:0] prdata_next;
  reg [63:0] target_next;

  wire wr = psel & penable & pwrite;
  wire rd = psel & ~penable & ~pwrite;
  wire hit = (ptp_clock >= target_reg);
  wire cmp_evt = hit & armed_reg;
  wire [SW-1:0] set_vec;
  wire [SW-1:0] clr_vec;
  wire sum_evt;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] st;
    integer i;
    begin
      for (i = 0; i < 32; i = i + 1)
        merge[i] = st[i/8] ? wd[i] : old[i];
    end
  endfunction

  function valid_addr;
    input [11:0] a;
    begin
      case (a)
        `PTCE_OFF_TGT_HI, `PTCE_OFF_TGT_LO, `PTCE_OFF_RLD_HI,
        `PTCE_OFF_RLD_LO, `PTCE_OFF_CFG, `PTCE_OFF_PINCFG,
        `PTCE_OFF_STS_EN, `PTCE_OFF_SYS_STS, `PTCE_OFF_SYS_EN:
          valid_addr = 1'b1;
        default:
          valid_addr = 1'b0;
      endcase
    end
  endfunction

  function reg_wr;
    input w;
    input [11:0] a;
    input [11:0] off;
    begin
      reg_wr = w && (a == off);
    end
  endfunction

  // Write decode
  wire wr_tgt_hi = reg_wr(wr, paddr, `PTCE_OFF_TGT_HI);
  wire wr_tgt_lo = reg_wr(wr, paddr, `PTCE_OFF_TGT_LO);
  wire wr_rld_hi = reg_wr(wr, paddr, `PTCE_OFF_RLD_HI);
  wire wr_rld_lo = reg_wr(wr, paddr, `PTCE_OFF_RLD_LO);
  wire wr_cfg = reg_wr(wr, paddr, `PTCE_OFF_CFG);
  wire wr_pincfg = reg_wr(wr, paddr, `PTCE_OFF_PINCFG);
  wire wr_sts_en = reg_wr(wr, paddr, `PTCE_OFF_STS_EN);
  wire wr_sys_en = reg_wr(wr, paddr, `PTCE_OFF_SYS_EN);
  wire [31:0] cfg_merged;
  wire [31:0] pincfg_merged;

  assign cfg_merged =
    merge({27'h0, cfg_reg}, pwdata, pstrb) & `PTCE_CFG_MASK;
  assign pincfg_merged =
    merge({26'h0, pincfg_reg}, pwdata, pstrb) & `PTCE_PIN_MASK;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~valid_addr(paddr);

  // Event set vector
  assign set_vec = {capture_event, cmp_evt};
  assign clr_vec = (wr_sts_en && pstrb[1]) ?
    {pwdata[8], pstrb[0] ? pwdata[7:0] : 8'h00} :
    (wr_sts_en && pstrb[0]) ? {1'b0, pwdata[7:0]} : {SW{1'b0}};
  assign sum_evt = |(sts_reg & en_reg);

  assign irq = sys_flag_reg & sys_en_reg;

  // Next compare target
  always @* begin
    target_next = target_reg;
    if (cmp_evt) begin
      if (cfg_reg[`PTCE_CFG_RELOAD_ADD])
        target_next = target_reg + {32'h00000000, reload_reg[31:0]};
      else
        target_next = reload_reg;
    end
  end

  // Compare target, software write wins over event update
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      target_reg <= 64'hFFFFFFFFFFFFFFFF;
    end else begin
      target_reg <= target_next;
      if (wr_tgt_hi)
        target_reg[63:32] <= merge(target_reg[63:32], pwdata, pstrb);
      if (wr_tgt_lo)
        target_reg[31:0] <= merge(target_reg[31:0], pwdata, pstrb);
    end
  end

  // Arming, so one crossing gives one event
  always @* begin
    armed_next = armed_reg | ~hit;
    if (cmp_evt)
      armed_next = 1'b0;
    if (wr_tgt_hi || wr_tgt_lo)
      armed_next = 1'b1;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_reg <= 1'b1;
    end else begin
      armed_reg <= armed_next;
    end
  end

  // Reload and add values
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_reg <= 64'h0000000000000000;
    end else begin
      if (wr_rld_hi)
        reload_reg[63:32] <= merge(reload_reg[63:32], pwdata, pstrb);
      if (wr_rld_lo)
        reload_reg[31:0] <= merge(reload_reg[31:0], pwdata, pstrb);
    end
  end

  // Event configuration
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= 5'h00;
    end else if (wr_cfg) begin
      cfg_reg <= cfg_merged[4:0];
    end
  end

  // Pin configuration
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pincfg_reg <= 6'h00;
    end else if (wr_pincfg) begin
      pincfg_reg <= pincfg_merged[5:0];
    end
  end

  // Status set and clear, set wins
  always @* begin
    sts_next = sts_reg & ~clr_vec;
    sts_next = sts_next | set_vec;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sts_reg <= {SW{1'b0}};
    end else begin
      sts_reg <= sts_next;
    end
  end

  // Interrupt enables
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_reg <= {SW{1'b0}};
    end else if (wr_sts_en) begin
      if (pstrb[2])
        en_reg[7:0] <= pwdata[`PTCE_EN_LO +: 8];
      if (pstrb[3])
        en_reg[8] <= pwdata[`PTCE_EN_LO + 8];
    end
  end

  // System summary flag
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_flag_reg <= 1'b0;
    end else begin
      sys_flag_reg <= sum_evt;
    end
  end

  // System enable
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_en_reg <= 1'b0;
    end else if (wr_sys_en && pstrb[3]) begin
      sys_en_reg <= pwdata[`PTCE_SYS_EVT];
    end
  end

  // Event pins
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_pin
      wire [1:0] mode = cfg_reg[`PTCE_CFG_MODE8_LO+2*g +: 2];
      wire pol = pincfg_reg[`PTCE_PIN_POL8+g];
      reg pin_reg;
      reg pulse_act_reg;
      reg [7:0] pulse_cnt_reg;

      // Pulse timer
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pulse_act_reg <= 1'b0;
          pulse_cnt_reg <= 8'h00;
        end else if (mode != `PTCE_MODE_PULSE) begin
          pulse_act_reg <= 1'b0;
        end else if (cmp_evt) begin
          pulse_act_reg <= 1'b1;
          pulse_cnt_reg <= PULSE_LEN - 8'h01;
        end else if (pulse_cnt_reg != 8'h00) begin
          pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
        end else begin
          pulse_act_reg <= 1'b0;
        end
      end

      // Level for toggle and timer modes, reserved mode holds
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_reg <= 1'b0;
        end else begin
          case (mode)
            `PTCE_MODE_PULSE:
              pin_reg <= 1'b0;
            `PTCE_MODE_TOGGLE:
              if (cmp_evt)
                pin_reg <= ~pin_reg;
            `PTCE_MODE_TIMER:
              pin_reg <= sts_reg[`PTCE_BIT_TIMER];
            default:
              pin_reg <= pin_reg;
          endcase
        end
      end

      assign event_pin_out[g] =
        ((mode == `PTCE_MODE_PULSE) ? pulse_act_reg : pin_reg) ^
        ~pol;
      assign event_pin_oe[g] = pincfg_reg[`PTCE_PIN_OE8+g];
      assign event_pin_buf_type[g] = pincfg_reg[`PTCE_PIN_BUF8+g];
    end
  endgenerate

  // Read data, captured in the setup cycle
  always @* begin
    prdata_next = prdata;
    if (rd) begin
      case (paddr)
        `PTCE_OFF_TGT_HI: prdata_next = target_reg[63:32];
        `PTCE_OFF_TGT_LO: prdata_next = target_reg[31:0];
        `PTCE_OFF_RLD_HI: prdata_next = reload_reg[63:32];
        `PTCE_OFF_RLD_LO: prdata_next = reload_reg[31:0];
        `PTCE_OFF_CFG: prdata_next = {27'h0, cfg_reg};
        `PTCE_OFF_PINCFG: prdata_next = {26'h0, pincfg_reg};
        `PTCE_OFF_STS_EN: prdata_next = {7'h00, en_reg, 7'h00, sts_reg};
        `PTCE_OFF_SYS_STS: prdata_next = {2'h0, sys_flag_reg, 29'h0};
        `PTCE_OFF_SYS_EN: prdata_next = {2'h0, sys_en_reg, 29'h0};
        default: prdata_next = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= prdata_next;
    end
  end
endmodule
`default_nettype wire

// *** include/ptce_consts.vh ***
`ifndef PTCE_CONSTS_VH
`define PTCE_CONSTS_VH
// Register byte offsets
`define PTCE_OFF_TGT_HI 12'h180
`define PTCE_OFF_TGT_LO 12'h184
`define PTCE_OFF_RLD_HI 12'h188
`define PTCE_OFF_RLD_LO 12'h18C
`define PTCE_OFF_CFG 12'h190
`define PTCE_OFF_PINCFG 12'h194
`define PTCE_OFF_STS_EN 12'h198
`define PTCE_OFF_SYS_STS 12'h1A0
`define PTCE_OFF_SYS_EN 12'h1A4
// Config register fields
`define PTCE_CFG_RELOAD_ADD 0
`define PTCE_CFG_MODE8_LO 1
`define PTCE_CFG_MODE9_LO 3
`define PTCE_CFG_MASK 32'h0000001F
// Pin configuration fields
`define PTCE_PIN_OE8 0
`define PTCE_PIN_OE9 1
`define PTCE_PIN_POL8 2
`define PTCE_PIN_POL9 3
`define PTCE_PIN_BUF8 4
`define PTCE_PIN_BUF9 5
`define PTCE_PIN_MASK 32'h0000003F
// Status and enable fields
`define PTCE_STS_W 9
`define PTCE_EN_LO 16
`define PTCE_BIT_TIMER 0
`define PTCE_BIT_P1TX 5
`define PTCE_BIT_P1RX 6
`define PTCE_BIT_P2TX 7
`define PTCE_BIT_P2RX 8
`define PTCE_BIT_MII_RX 4
`define PTCE_SYS_EVT 29
// Pin event modes
`define PTCE_MODE_PULSE 2'h0
`define PTCE_MODE_TOGGLE 2'h1
`define PTCE_MODE_TIMER 2'h2
// Pulse timing
`define PTCE_PULSE_NS 100
`define PTCE_CLK_NS 4
`endif

// *** testbench/ptce_event_irq_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module ptce_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] event_pin_oe,
  input wire logic [1:0] event_pin_buf_type,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire wr_acc = psel && penable && pwrite;
  wire rd_setup = psel && !penable && !pwrite;
  wire rd_acc = psel && penable && !pwrite;
  sequence s_recent_wr;
    $past(wr_acc) || $past(wr_acc, 2);
  endsequence
  property p_buf;
    !$stable(event_pin_buf_type) |-> $past(wr_acc);
  endproperty
  a_buf: assert property (p_buf) else $error("buffer type moved");
  property p_oe;
    !$stable(event_pin_oe) |-> $past(wr_acc);
  endproperty
  a_oe: assert property (p_oe) else $error("enable moved");
  property p_irq_fall;
    $fell(irq) |-> s_recent_wr;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell");
  property p_ok;
    psel && penable && paddr == 12'h198 |-> !pslverr && pready;
  endproperty
  a_ok: assert property (p_ok) else $error("status access refused");
  property p_rsvd;
    rd_acc && paddr == 12'h198 |-> prdata[31:25] == 0 && prdata[15:9] == 0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_sys;
    rd_acc && paddr == 12'h1A0 |-> (prdata & 32'hDFFFFFFF) == 0;
  endproperty
  a_sys: assert property (p_sys) else $error("system status bits");
  property p_hold;
    !$stable(prdata) |-> $past(rd_setup);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_err;
    psel && penable && paddr > 12'h1A4 |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
endmodule
`default_nettype wire

// *** testbench/ptce_event_irq_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module ptce_event_irq_bench;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic [63:0] ptp_clock = 0;
  logic [8:1] capture_event = 0;
  logic [1:0] event_pin_out, event_pin_oe, event_pin_buf_type;
  logic pready, pslverr, irq;
  int num_errors = 0, compares = 0, cycles = 0;
  ptce_event_irq uut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .ptp_clock,
    .capture_event, .event_pin_out, .event_pin_oe, .event_pin_buf_type,
    .irq);
  always #2 clk = ~clk;
  task automatic results;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task automatic pins(input logic [1:0] e);
    repeat (3) @(posedge clk);
    chk("pins", {30'h0, event_pin_out}, {30'h0, e});
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(12'h198, 32'h0, "sts_en");
    rdc(12'h190, 32'h0, "cfg");
    wr(12'h190, 32'hFFFFFFFF);
    rdc(12'h190, 32'h1F, "cfg_rw");
    apb(1'b0, 12'h1FC, 32'h0);
    chk("err", {31'h0, er}, 32'h1);
    for (int i = 1; i < 9; i++) begin
      capture_event <= 8'h1 << (i - 1);
      @(posedge clk);
    end
    capture_event <= 8'h0;
    rdc(12'h198, 32'h1FE, "sts");
    wr(12'h198, 32'hAA);
    rdc(12'h198, 32'h154, "w1c");
    wr(12'h198, 32'h00400000);
    rdc(12'h1A0, 32'h20000000, "sys");
    chk("irq", {31'h0, irq}, 32'h0);
    wr(12'h1A4, 32'h20000000);
    repeat (3) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(12'h198, 32'h00400040);
    repeat (3) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    rdc(12'h198, 32'h00400114, "sts");
    wr(12'h194, 32'h1F);
    chk("oe", {30'h0, event_pin_oe}, 32'h3);
    chk("buf", {30'h0, event_pin_buf_type}, 32'h1);
    wr(12'h18C, 32'h100);
    wr(12'h180, 32'h0);
    wr(12'h184, 32'h200);
    wr(12'h190, 32'h09);
    ptp_clock <= 64'h200;
    pins(2'b11);
    repeat (30) @(posedge clk);
    chk("pins", {30'h0, event_pin_out}, 32'h2);
    rdc(12'h184, 32'h300, "tgt");
    rdc(12'h198, 32'h00400115, "tmr");
    wr(12'h188, 32'h0);
    wr(12'h190, 32'h08);
    ptp_clock <= 64'h300;
    pins(2'b01);
    rdc(12'h184, 32'h100, "rld");
    wr(12'h198, 32'h00400001);
    wr(12'h190, 32'h16);
    wr(12'h184, 32'h400);
    ptp_clock <= 64'h400;
    pins(2'b10);
    wr(12'h194, 32'h0B);
    pins(2'b11);
    wr(12'h194, 32'h0);
    chk("oe", {30'h0, event_pin_oe}, 32'h0);
    results();
  end
endmodule
bind ptce_event_irq ptce_checker chk_i (.clk, .rst_n, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .event_pin_oe,
  .event_pin_buf_type, .irq);
`default_nettype wire
